// file: split_desc_params.svh
/*
  Constants of the split bulk/control descriptor engine: register byte
  offsets, descriptor field positions, codes and reset values.
  Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef SPLIT_DESC_PARAMS_SVH
`define SPLIT_DESC_PARAMS_SVH

// APB byte offsets, one aligned word each except PAYLOAD_BASE, which starts the payload window
`define OFF_DW0 12'h000
`define OFF_DW1 12'h004
`define OFF_DW2 12'h008
`define OFF_DW3 12'h00C
`define OFF_IRQ_STAT 12'h010
`define OFF_IRQ_MASK 12'h014
`define OFF_ENGINE 12'h018
`define PAYLOAD_BASE 12'h400
// Descriptor word 0
`define DW0_VALID 0
`define DW0_LEN_LO 3
`define DW0_LEN_HI 17
`define DW0_MPS_LO 18
`define DW0_MPS_HI 28
`define DW0_EP_LSB 31
// Descriptor word 1 (descriptor bits 63..32)
`define DW1_EP_LO 0
`define DW1_EP_HI 2
`define DW1_FN_LO 3
`define DW1_FN_HI 9
`define DW1_TOK_LO 10
`define DW1_TOK_HI 11
`define DW1_CLS_LO 12
`define DW1_CLS_HI 13
`define DW1_SPLIT 14
`define DW1_RETIRE 15
`define DW1_SE_LO 16
`define DW1_SE_HI 17
`define DW1_PORT_LO 18
`define DW1_PORT_HI 24
`define DW1_HUB_LO 25
`define DW1_HUB_HI 31
// Descriptor word 2
`define DW2_OFS_LO 8
`define DW2_OFS_HI 23
`define DW2_RL_LO 25
`define DW2_RL_HI 28
// Descriptor word 3 (descriptor bits 127..96 region used here)
`define DW3_XFER_LO 0
`define DW3_XFER_HI 14
`define DW3_NAK_LO 19
`define DW3_NAK_HI 22
`define DW3_CERR_LO 23
`define DW3_CERR_HI 24
// Field codes
`define SE_LOW 2'h2
`define SE_FULL 2'h0
`define TOK_INVALID 2'h3
`define CLS_CONTROL 2'h0
`define CLS_BULK 2'h2
`define FS_MAX_PAYLOAD 11'h040
// Interrupt status bit positions
`define IRQ_DONE 0
`define IRQ_NAK 1
`define IRQ_ERR 2
`define IRQ_RETIRE 3
`define IRQ_W 4
// Reset values
`define RESET_WORD 32'h0000_0000
`define RESET_IRQ 4'h0

`endif

// file: split_desc_pkg.sv
/*
  Types of the split bulk/control descriptor engine.
  Assumes nothing of its surroundings.
*/
package split_desc_pkg;

  // Engine states
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} engine_state_e;

  // Outcome reported by the link for one transaction
  typedef enum logic [2:0] {RES_ACK, RES_NAK, RES_NYET, RES_ERROR, RES_STALL} link_result_e;

endpackage

// file: payload_ram.sv
/*
  Payload buffer: one write port, one read port, registered read data.
  Assumes a single clock; the caller arbitrates between writers.
*/
`timescale 1ns/1ps
`default_nettype none

module payload_ram #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Write port
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  // Read port
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  ////////////////////////////////////////////////////////////////////
  // Storage has no reset, to keep it a plain RAM
  always_ff @(posedge mclk)
  begin
    if (ce && wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read data held in a register until the next read
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdData <= '0;
    end
    else if (ce && rdEn)
    begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

`default_nettype wire

// file: split_bulk_control_descriptor.sv
/*
  Descriptor engine for full/low-speed bulk and control split transfers,
  with APB register access, payload buffer and one interrupt line.
  Assumes a link engine outside that runs each transaction on txnReq and
  answers with a one-cycle linkDone; all inputs synchronous to mclk.
*/
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "split_desc_params.svh"

module split_bulk_control_descriptor
  import split_desc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Transaction request to link
  output logic txnReq,
  output logic [1:0] txnToken,
  output logic [1:0] txnEndpointClass,
  output logic [6:0] txnFunction,
  output logic [3:0] txnEndpoint,
  output logic txnSplit,
  output logic txnLowSpeed,
  output logic [6:0] txnHub,
  output logic [6:0] txnPort,
  output logic [10:0] txnMaxPayload,
  output logic [14:0] txnLength,
  output logic [14:0] txnBytesDone,
  // Transaction result from link
  input wire logic linkDone,
  input wire link_result_e linkResult,
  input wire logic [10:0] linkBytes,
  // Payload access from link
  input wire logic linkRdEn,
  input wire logic [ADDR_W-1:0] linkRdIdx,
  output logic [31:0] linkRdData,
  input wire logic linkWrEn,
  input wire logic [ADDR_W-1:0] linkWrIdx,
  input wire logic [31:0] linkWrData
);

  logic [31:0] dw0_r, dw1_r, dw2_r, dw3_r, cfg_r, regRd_r, ramRdata;
  logic [`IRQ_W-1:0] irqStat_r, irqMask_r, irqSet;
  logic [1:0] cerrInit_r;
  logic [ADDR_W-1:0] base_r, ramWrAddr, ramRdAddr;
  logic lowSpeed_r, rdPend_r;
  engine_state_e state_r;

  ////////////////////////////////////////////////////////////////////
  // Descriptor fields; reserved bits are simply never looked at
  logic valid, retire, split;
  logic [1:0] tok, cls, se, cerr;
  logic [3:0] rl, nak_retry_count;
  logic [10:0] mps;
  logic [14:0] len, xfer;
  logic [15:0] ofs, sumXfer;
  assign valid = dw0_r[`DW0_VALID];
  assign len = dw0_r[`DW0_LEN_HI:`DW0_LEN_LO];
  assign mps = dw0_r[`DW0_MPS_HI:`DW0_MPS_LO];
  assign tok = dw1_r[`DW1_TOK_HI:`DW1_TOK_LO];
  assign cls = dw1_r[`DW1_CLS_HI:`DW1_CLS_LO];
  assign split = dw1_r[`DW1_SPLIT];
  assign retire = dw1_r[`DW1_RETIRE];
  assign se = dw1_r[`DW1_SE_HI:`DW1_SE_LO];
  assign ofs = dw2_r[`DW2_OFS_HI:`DW2_OFS_LO];
  assign rl = dw2_r[`DW2_RL_HI:`DW2_RL_LO];
  assign xfer = dw3_r[`DW3_XFER_HI:`DW3_XFER_LO];
  assign nak_retry_count = dw3_r[`DW3_NAK_HI:`DW3_NAK_LO];
  assign cerr = dw3_r[`DW3_CERR_HI:`DW3_CERR_LO];
  assign sumXfer = {1'b0, xfer} + {5'h00, linkBytes};

  ////////////////////////////////////////////////////////////////////
  // Engine events
  logic busy, idleReq, badCfg, result, evStart, evRetire, evBad;
  logic evDone, evNakExp, evFatal, clearValid;
  assign busy = (state_r == ST_BUSY);
  assign idleReq = !busy && valid && !retire;
  // Unknown token or class, or oversize full-speed packet, is fatal
  assign badCfg = (tok == `TOK_INVALID)
    || (cls != `CLS_CONTROL && cls != `CLS_BULK)
    || (split && se == `SE_FULL && mps > `FS_MAX_PAYLOAD);
  assign evStart = idleReq && !badCfg;
  assign evBad = idleReq && badCfg;
  assign evRetire = valid && retire;
  assign result = busy && linkDone && !retire;
  // Finished when length reached or a short packet ends the data
  assign evDone = result && linkResult == RES_ACK
    && (sumXfer >= {1'b0, len} || linkBytes < mps);
  assign evNakExp = result && linkResult == RES_NAK && rl != 4'h0
    && nak_retry_count <= 4'h1;
  assign evFatal = result && (linkResult == RES_STALL
    || (linkResult == RES_ERROR && cerr <= 2'h1));
  assign clearValid = evRetire || evBad || evDone || evNakExp || evFatal;

  ////////////////////////////////////////////////////////////////////
  // APB decode; register reads take one wait cycle, RAM reads and writes yield to link
  function automatic logic isMapped(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'h0};
    isMapped = (a[11:10] == 2'h1) || w == `OFF_DW0 || w == `OFF_DW1
      || w == `OFF_DW2 || w == `OFF_DW3 || w == `OFF_IRQ_STAT
      || w == `OFF_IRQ_MASK || w == `OFF_ENGINE;
  endfunction

  logic apbAcc, isRam, rdIssue, apbWr;
  logic [11:0] wordAddr;
  assign apbAcc = psel && penable;
  assign wordAddr = {paddr[11:2], 2'h0};
  assign isRam = (paddr[11:10] == 2'h1);
  assign rdIssue = apbAcc && !pwrite && !rdPend_r && !(isRam && linkRdEn);
  assign pready = pwrite ? !(isRam && linkWrEn) : rdPend_r;
  assign pslverr = apbAcc && pready && !isMapped(paddr);
  assign apbWr = apbAcc && pwrite && pready;
  assign prdata = isRam ? ramRdata : regRd_r;

  // Read pending flag, dropped once the access completes
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdPend_r <= 1'b0;
    end
    else if (ce)
    begin
      rdPend_r <= rdIssue ? 1'b1 : (apbAcc && pready ? 1'b0 : rdPend_r);
    end
  end

  // Register read mux, captured at the first access cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRd_r <= `RESET_WORD;
    end
    else if (ce && rdIssue)
    begin
      case (wordAddr)
        `OFF_DW0: regRd_r <= dw0_r;
        `OFF_DW1: regRd_r <= dw1_r;
        `OFF_DW2: regRd_r <= dw2_r;
        `OFF_DW3: regRd_r <= dw3_r;
        `OFF_IRQ_STAT: regRd_r <= {28'h000_0000, irqStat_r};
        `OFF_IRQ_MASK: regRd_r <= {28'h000_0000, irqMask_r};
        `OFF_ENGINE: regRd_r <= {30'h0000_0000, lowSpeed_r, busy};
        default: regRd_r <= `RESET_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Words 0 and 3 belong to the engine while busy; writes then ignored
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dw0_r <= `RESET_WORD;
    end
    else if (ce)
    begin
      if (apbWr && !busy && wordAddr == `OFF_DW0)
      begin
        dw0_r <= pwdata;
      end
      else if (clearValid)
      begin
        dw0_r[`DW0_VALID] <= 1'b0;
      end
    end
  end

  // Words 1 and 2 are software-only; abort stays writable at all times
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dw1_r <= `RESET_WORD;
      dw2_r <= `RESET_WORD;
    end
    else if (ce && apbWr)
    begin
      if (wordAddr == `OFF_DW1)
      begin
        dw1_r <= pwdata;
      end
      if (wordAddr == `OFF_DW2 && !busy)
      begin
        dw2_r <= pwdata;
      end
    end
  end

  // Progress, NAK and error counters updated per link result
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dw3_r <= `RESET_WORD;
    end
    else if (ce)
    begin
      if (apbWr && !busy && wordAddr == `OFF_DW3)
      begin
        dw3_r <= pwdata;
      end
      else if (result)
      begin
        case (linkResult)
          RES_ACK:
          begin
            dw3_r[`DW3_XFER_HI:`DW3_XFER_LO] <= sumXfer[14:0];
            if (rl != 4'h0)
            begin
              dw3_r[`DW3_NAK_HI:`DW3_NAK_LO] <= rl;
            end
          end
          RES_NAK:
          begin
            dw3_r[`DW3_CERR_HI:`DW3_CERR_LO] <= cerrInit_r;
            if (rl != 4'h0 && nak_retry_count != 4'h0)
            begin
              dw3_r[`DW3_NAK_HI:`DW3_NAK_LO] <= nak_retry_count - 4'h1;
            end
          end
          RES_NYET: dw3_r[`DW3_CERR_HI:`DW3_CERR_LO] <= cerrInit_r;
          RES_ERROR:
          begin
            if (cerr != 2'h0)
            begin
              dw3_r[`DW3_CERR_HI:`DW3_CERR_LO] <= cerr - 2'h1;
            end
          end
          default: dw3_r <= dw3_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Engine state; any clearing event returns it to idle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
    end
    else if (ce)
    begin
      case (state_r)
        ST_IDLE: state_r <= evStart ? ST_BUSY : ST_IDLE;
        ST_BUSY: state_r <= clearValid ? ST_IDLE : ST_BUSY;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Routing captured at start so later word-1 writes cannot skew it
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_r <= `RESET_WORD;
      lowSpeed_r <= 1'b0;
      cerrInit_r <= 2'h0;
      base_r <= '0;
    end
    else if (ce && evStart)
    begin
      cfg_r <= dw1_r;
      lowSpeed_r <= split && se == `SE_LOW;
      cerrInit_r <= cerr;
      base_r <= ADDR_W'({ofs, 1'b0});
    end
  end

  // Request fields, all from flops
  assign txnReq = busy && !retire;
  assign txnToken = cfg_r[`DW1_TOK_HI:`DW1_TOK_LO];
  assign txnEndpointClass = cfg_r[`DW1_CLS_HI:`DW1_CLS_LO];
  assign txnFunction = cfg_r[`DW1_FN_HI:`DW1_FN_LO];
  assign txnEndpoint = {cfg_r[`DW1_EP_HI:`DW1_EP_LO], dw0_r[`DW0_EP_LSB]};
  assign txnSplit = cfg_r[`DW1_SPLIT];
  assign txnLowSpeed = lowSpeed_r;
  assign txnHub = cfg_r[`DW1_HUB_HI:`DW1_HUB_LO];
  assign txnPort = cfg_r[`DW1_PORT_HI:`DW1_PORT_LO];
  assign txnMaxPayload = mps;
  assign txnLength = len;
  assign txnBytesDone = xfer;

  ////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, write one to clear, a new event wins the clear
  assign irqSet = {evRetire, evFatal || evBad, evNakExp, evDone};
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqStat_r <= `RESET_IRQ;
      irqMask_r <= `RESET_IRQ;
    end
    else if (ce)
    begin
      if (apbWr && wordAddr == `OFF_IRQ_STAT)
      begin
        irqStat_r <= (irqStat_r & ~pwdata[`IRQ_W-1:0]) | irqSet;
      end
      else
      begin
        irqStat_r <= irqStat_r | irqSet;
      end
      if (apbWr && wordAddr == `OFF_IRQ_MASK)
      begin
        irqMask_r <= pwdata[`IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irqStat_r & irqMask_r);

  ////////////////////////////////////////////////////////////////////
  // Payload buffer; link has priority, link addresses relative to offset, APB addresses absolute
  logic ramWrEn, ramRdEn;
  assign ramWrEn = linkWrEn || (apbWr && isRam);
  assign ramWrAddr = linkWrEn ? base_r + linkWrIdx : paddr[ADDR_W+1:2];
  assign ramRdEn = linkRdEn || (rdIssue && isRam);
  assign ramRdAddr = linkRdEn ? base_r + linkRdIdx : paddr[ADDR_W+1:2];
  assign linkRdData = ramRdata;

  payload_ram #(.DATA_W(32), .ADDR_W(ADDR_W)) u_ram (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(linkWrEn ? linkWrData : pwdata),
    .rdEn(ramRdEn),
    .rdAddr(ramRdAddr),
    .rdData(ramRdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence nakSeen;
    ce && result && linkResult == RES_NAK;
  endsequence
  sequence reqRise;
    ce && $rose(txnReq);
  endsequence

  chk_nak_ignored: assert property (nakSeen ##0 rl == 4'h0 |=> valid && $stable(nak_retry_count))
    else $error("NAK retired descriptor with zero reload");
  chk_nak_expiry: assert property (nakSeen ##0 (rl != 4'h0 && nak_retry_count == 4'h1)
    |=> !valid && state_r == ST_IDLE && irqStat_r[`IRQ_NAK])
    else $error("NAK counter expiry did not retire descriptor");
  chk_cerr_restore: assert property (ce && result && (linkResult == RES_NAK
    || linkResult == RES_NYET) |=> cerr == $past(cerrInit_r))
    else $error("error counter not restored");
  chk_cerr_expiry: assert property (ce && result && linkResult == RES_ERROR
    && cerr == 2'h1 |=> !valid ##1 !txnReq)
    else $error("error counter expiry did not stop engine");
  chk_abort_stop: assert property (ce && busy && retire |=> !txnReq && !valid)
    else $error("abort did not stop processing");
  chk_route_fields: assert property (reqRise |-> txnHub == $past(dw1_r[31:25])
    && txnPort == $past(dw1_r[24:18]) && txnSplit == $past(split))
    else $error("hub routing fields wrong");
  chk_speed_code: assert property (reqRise |-> txnLowSpeed == ($past(split)
    && $past(se) == 2'h2))
    else $error("split speed decode wrong");
  chk_endpoint_addr: assert property (reqRise |-> txnEndpoint == {$past(dw1_r[2:0]),
    $past(dw0_r[31])} && txnFunction == $past(dw1_r[9:3]))
    else $error("endpoint or function address wrong");
  chk_token_class: assert property (txnReq |-> txnToken != 2'h3
    && (txnEndpointClass == 2'h0 || txnEndpointClass == 2'h2))
    else $error("illegal token or class issued");
  chk_fs_limit: assert property (ce && idleReq && split && se == 2'h0 && mps > 11'd64
    |=> state_r == ST_IDLE && !valid)
    else $error("oversize full-speed packet accepted");
  chk_done_clear: assert property (ce && evDone |=> !valid && irqStat_r[`IRQ_DONE]
    && txnBytesDone == $past(sumXfer[14:0]))
    else $error("finished descriptor still active");
  chk_buffer_base: assert property (ce && busy && linkRdEn && linkRdIdx == '0
    |-> ramRdAddr == ADDR_W'({ofs, 1'b0}))
    else $error("payload offset mapping wrong");

endmodule

`default_nettype wire

// file: link_partner.sv
/*
  Behavioural USB function behind the hub translator. It answers each
  transaction of the engine from a queue of scripted outcomes.
  Assumes the bench fills q and inWord; one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module link_partner
  import split_desc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Request from the engine
  input wire logic txnReq,
  input wire logic [1:0] txnToken,
  input wire logic [10:0] txnMaxPayload,
  // Outcome to the engine
  output logic linkDone,
  output var link_result_e linkResult,
  output logic [10:0] linkBytes,
  // Payload buffer access
  output logic linkRdEn,
  output logic [7:0] linkRdIdx,
  output logic linkWrEn,
  output logic [7:0] linkWrIdx,
  output logic [31:0] linkWrData
);
  int q[$];
  logic [31:0] inWord;
  int waitCnt;
  int r;

  ////////////////////////////////////////////////////////////////////////////
  // OUT transfers keep reading word 0 of the buffer; data not inspected
  assign linkRdEn = txnReq && txnToken == 2'b00;
  assign linkRdIdx = 8'h00;
  assign linkWrIdx = 8'h00;

  // One outcome per transaction 1 to 4 cycles after the request is seen; never two pulses in a row
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      linkDone <= 1'b0;
      linkWrEn <= 1'b0;
      linkResult <= RES_ACK;
      linkBytes <= 11'h000;
      linkWrData <= 32'h0000_0000;
      waitCnt <= 2;
    end
    else
    begin
      linkDone <= 1'b0;
      linkWrEn <= 1'b0;
      // Idle lines toggle, so a stale value is never mistaken for an answer
      linkResult <= link_result_e'(~linkResult);
      linkBytes <= ~linkBytes;
      linkWrData <= ~linkWrData;
      if (txnReq !== 1'b1 || linkDone || q.size() == 0)
        waitCnt <= 1 + $urandom_range(3);
      else if (waitCnt > 0)
        waitCnt <= waitCnt - 1;
      else
      begin
        r = q.pop_front();
        linkDone <= 1'b1;
        linkResult <= link_result_e'(r[18:16]);
        // A function never returns more than one packet's worth
        linkBytes <= (r[10:0] > txnMaxPayload) ? txnMaxPayload : r[10:0];
        if (txnToken == 2'b01 && r[18:16] == 3'd0)
        begin
          linkWrEn <= 1'b1;
          linkWrData <= inWord;
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench of the split descriptor engine: APB master, link
  partner, behavioural outcome model and comparisons.
  Assumes the hand-over timing of the engine; one 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "split_desc_params.svh"

module tb_top
  import split_desc_pkg::*;
;
  // Design signals
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq, txnReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, linkWrData;
  logic [1:0] txnToken, txnEndpointClass;
  logic [6:0] txnFunction, txnHub, txnPort;
  logic [3:0] txnEndpoint;
  logic txnSplit, txnLowSpeed, linkDone, linkRdEn, linkWrEn;
  logic [10:0] txnMaxPayload, linkBytes;
  logic [14:0] txnLength, txnBytesDone;
  logic [7:0] linkRdIdx, linkWrIdx;
  link_result_e linkResult;
  // Bench state
  int err_total = 0;
  int checks_done = 0;
  int reqRises = 0;
  int resQ[$];
  logic [31:0] rdv, inw;
  logic errv, prevReq;
  logic [15:0] expA;
  logic [14:0] expB;
  logic [25:0] expC;

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  split_bulk_control_descriptor #(.ADDR_W(8)) dut (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .txnReq(txnReq), .txnToken(txnToken),
    .txnEndpointClass(txnEndpointClass), .txnFunction(txnFunction),
    .txnEndpoint(txnEndpoint), .txnSplit(txnSplit), .txnLowSpeed(txnLowSpeed),
    .txnHub(txnHub), .txnPort(txnPort), .txnMaxPayload(txnMaxPayload),
    .txnLength(txnLength), .txnBytesDone(txnBytesDone), .linkDone(linkDone),
    .linkResult(linkResult), .linkBytes(linkBytes), .linkRdEn(linkRdEn),
    .linkRdIdx(linkRdIdx), .linkRdData(), .linkWrEn(linkWrEn), .linkWrIdx(linkWrIdx),
    .linkWrData(linkWrData));

  link_partner u_link (
    .mclk(mclk), .reset_n(reset_n), .txnReq(txnReq), .txnToken(txnToken),
    .txnMaxPayload(txnMaxPayload), .linkDone(linkDone), .linkResult(linkResult),
    .linkBytes(linkBytes), .linkRdEn(linkRdEn), .linkRdIdx(linkRdIdx),
    .linkWrEn(linkWrEn), .linkWrIdx(linkWrIdx), .linkWrData(linkWrData));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 1, n < 50);
  endtask

  function int res(input int k, input int b);
    return (k << 16) | b;
  endfunction

  // Count request starts
  always @(posedge mclk)
  begin
    prevReq <= txnReq;
    if (txnReq === 1'b1 && prevReq !== 1'b1)
      reqRises <= reqRises + 1;
  end

  // Transaction fields seen by the link
  initial
    forever
    begin
      @(posedge txnReq);
      @(negedge mclk);
      chk("txn id", expA, {txnToken, txnEndpointClass, txnFunction, txnEndpoint, txnSplit});
      if (expA[0])
        chk("txn route", expB, {txnHub, txnPort, txnLowSpeed});
      chk("txn sizes", expC, {txnMaxPayload, txnLength});
    end

  ////////////////////////////////////////////////////////////////////////////
  // Runs one descriptor against the outcomes in resQ and checks the model
  task automatic run_desc(input logic sp, input logic [1:0] se, input logic [1:0] tk,
    input logic [1:0] cl, input logic [3:0] rl, input logic [1:0] cr,
    input logic [14:0] len, input logic [10:0] mps, input logic ab);
    logic [6:0] hub, port, fn, off;
    logic [3:0] ep, msk;
    logic [31:0] dw1;
    int bytes, cerr, nak, v, st, k, b, rises, n;
    bit bad;
    hub = 7'($urandom);
    port = 7'($urandom);
    fn = 7'($urandom);
    off = 7'($urandom);
    ep = 4'($urandom);
    msk = 4'($urandom);
    inw = $urandom;
    bad = (tk == 2'b11) || cl[0] || (sp && se == 2'b00 && mps > 64);
    v = 1;
    st = 0;
    bytes = 0;
    cerr = cr;
    nak = rl;
    if (bad)
      st = 4;
    else if (ab)
      st = 8;
    else
      foreach (resQ[i])
        if (v)
        begin
          k = resQ[i] >> 16;
          b = resQ[i] & 'h7FF;
          case (k)
            0: begin bytes += b; if (rl != 0) nak = rl; if (bytes >= len || b < mps) st = 1; end
            1: begin cerr = cr; if (rl != 0) begin if (nak <= 1) st = 2; else nak--; end end
            2: cerr = cr;
            3: if (cerr <= 1) st = 4; else cerr--;
            default: st = 4;
          endcase
          if (st != 0) v = 0;
        end
    expA = {tk, cl, fn, ep, sp};
    expB = {hub, port, sp && se == 2'b10};
    expC = {mps, len};
    u_link.q = resQ;
    u_link.inWord = inw;
    rises = reqRises;
    dw1 = {hub, port, se, 1'b0, sp, cl, tk, fn, ep[3:1]};
    apb(1'b1, `OFF_IRQ_MASK, {28'h0, msk});
    apb(1'b1, `OFF_DW1, dw1);
    apb(1'b1, `OFF_DW2, {3'($urandom), rl, 1'($urandom), 9'h0, off, 8'($urandom)});
    apb(1'b1, `OFF_DW3, {7'h0, cr, rl, 4'h0, 15'h0});
    apb(1'b1, `OFF_DW0, {ep[0], 2'($urandom), mps, len, 2'($urandom), 1'b1});
    if (ab)
    begin
      repeat (8) @(negedge mclk);
      chk("busy before abort", 1, txnReq);
      apb(1'b1, `OFF_DW1, dw1 | 32'h0000_8000);
    end
    n = 0;
    do
    begin
      apb(1'b0, `OFF_DW0, 32'h0);
      n++;
    end
    while (rdv[0] === 1'b1 && n < 300);
    chk("active bit", 0, rdv[0]);
    chk("request starts", bad ? 0 : 1, reqRises - rises);
    chk("request idle", 0, txnReq);
    apb(1'b0, `OFF_DW3, 32'h0);
    chk("bytes done", bytes, rdv[14:0]);
    chk("bytes port", bytes, txnBytesDone);
    apb(1'b0, `OFF_IRQ_STAT, 32'h0);
    chk("status", st, rdv[3:0]);
    @(negedge mclk);
    chk("irq masked", (st & msk) != 0, irq);
    apb(1'b1, `OFF_IRQ_MASK, 32'h0000_000F);
    @(negedge mclk);
    chk("irq unmasked", st != 0, irq);
    apb(1'b1, `OFF_IRQ_STAT, 32'h0000_000F);
    @(negedge mclk);
    chk("irq cleared", 0, irq);
    if (tk == 2'b01 && st == 1)
    begin
      apb(1'b0, 12'h400 + {off, 3'b000}, 32'h0);
      chk("payload word", inw, rdv);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs far fewer cycles than this
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    test_done;
  end

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    void'($urandom(32'hb4cd_ef9d));
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 7; a++)
    begin
      apb(1'b0, 12'(a * 4), 32'h0);
      chk("reset value", 0, rdv);
    end
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped read", {31'h0, 1'b1}, {rdv[30:0], errv});
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
    chk("unmapped write", 1, errv);
    resQ = {res(0, 64), res(0, 36)};
    run_desc(1'b1, 2'b00, 2'b00, 2'b00, 4'h0, 2'h3, 15'd100, 11'd64, 1'b0);
    resQ = {res(0, 8), res(2, 0), res(0, 3)};
    run_desc(1'b1, 2'b10, 2'b01, 2'b10, 4'h0, 2'h3, 15'd200, 11'd8, 1'b0);
    resQ = {};
    repeat (10) resQ.push_back(res(1, 0));
    resQ = {resQ, res(3, 0), res(3, 0), res(0, 8)};
    run_desc(1'b1, 2'b00, 2'b10, 2'b00, 4'h0, 2'h3, 15'd8, 11'd8, 1'b0);
    resQ = {res(1, 0), res(1, 0), res(1, 0)};
    run_desc(1'b0, 2'b00, 2'b01, 2'b10, 4'h3, 2'h3, 15'd64, 11'd64, 1'b0);
    resQ = {res(3, 0), res(3, 0), res(1, 0), res(3, 0), res(3, 0), res(3, 0)};
    run_desc(1'b1, 2'b10, 2'b00, 2'b10, 4'h0, 2'h3, 15'd64, 11'd8, 1'b0);
    resQ = {res(4, 0)};
    run_desc(1'b1, 2'b00, 2'b01, 2'b00, 4'h0, 2'h3, 15'd16, 11'd16, 1'b0);
    resQ = {};
    run_desc(1'b1, 2'b00, 2'b00, 2'b10, 4'h0, 2'h3, 15'd64, 11'd64, 1'b1);
    for (int i = 0; i < 4; i++)
      run_desc(1'b1, 2'b00, i == 0 ? 2'b11 : 2'b00, i == 1 ? 2'b01 : (i == 2 ? 2'b11 : 2'b10),
        4'h0, 2'h3, 15'd64, i == 3 ? 11'd65 : 11'd64, 1'b0);
    test_done;
  end
endmodule

`default_nettype wire
